// File: src/ea_mode_check.sv
// Effective address legality per instruction kind
`timescale 1ns/1ps
module ea_mode_check (
   // Instruction kind and address fields
   input wire fp_pkg::ea_kind_t i_kind,
   input wire logic [2:0] i_mode,
   input wire logic [2:0] i_reg,
   input wire logic [2:0] i_fmt,
   // Verdict
   output logic o_legal
);
   wire is_ext = i_mode == fp_pkg::EA_EXT;
   wire abs_ok = is_ext &&
      (i_reg == fp_pkg::EXT_ABS_W || i_reg == fp_pkg::EXT_ABS_L);
   wire ctrl_alt = i_mode == fp_pkg::EA_IND || i_mode == fp_pkg::EA_DISP ||
      i_mode == fp_pkg::EA_INDEX || abs_ok;
   // Plain register sources only for short integer or single formats
   wire dreg_fmt_ok = i_fmt == fp_pkg::FMT_LONG ||
      i_fmt == fp_pkg::FMT_SINGLE || i_fmt == fp_pkg::FMT_WORD ||
      i_fmt == fp_pkg::FMT_BYTE;
   wire save_ok = ctrl_alt || i_mode == fp_pkg::EA_PREDEC;
   // Mode 7 codes above immediate are unassigned
   wire scale_ok = (i_mode == fp_pkg::EA_DREG) ? dreg_fmt_ok :
      (i_mode == fp_pkg::EA_AREG) ? 1'b0 :
      is_ext ? (i_reg <= fp_pkg::EXT_IMM) : 1'b1;
   wire setcc_ok = ctrl_alt || i_mode == fp_pkg::EA_DREG ||
      i_mode == fp_pkg::EA_POSTINC || i_mode == fp_pkg::EA_PREDEC;
   // Verdict selected by kind
   assign o_legal = (i_kind == fp_pkg::EA_FOR_SAVE) ? save_ok :
      (i_kind == fp_pkg::EA_FOR_SCALE) ? scale_ok :
      (i_kind == fp_pkg::EA_FOR_SETCC) ? setcc_ok : 1'b1;
endmodule : ea_mode_check

// File: src/fp_coproc_device.sv
// Coprocessor end: save answer, exponent scaling and set-on-condition
`timescale 1ns/1ps
module fp_coproc_device #(
   parameter logic [2:0] CPID = fp_pkg::CPID_DEFAULT,
   parameter logic [7:0] VERSION = fp_pkg::VERSION_DEFAULT
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Link to the main processor
   fp_link_if.dev link,
   // Register preload and observation
   input wire logic i_load_valid,
   input wire logic [2:0] i_load_idx,
   input wire logic [fp_pkg::XW-1:0] i_load_value,
   input wire logic i_status_load,
   input wire logic [31:0] i_status_value,
   input wire logic [2:0] i_peek_idx,
   output logic [fp_pkg::XW-1:0] o_peek_value,
   output logic [31:0] o_status_word
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_RESP = 2'b10
   } dev_state_t;

   dev_state_t state_reg, state_next;
   logic ready_reg, resp_valid_reg;
   fp_pkg::resp_code_t code_reg, code_next;
   logic [15:0] data_reg, data_next;
   logic [15:0] op_reg, ext_reg;
   logic [fp_pkg::XW-1:0] opnd_reg;
   logic [fp_pkg::XW-1:0] fpr_reg [8];
   logic [fp_pkg::XW-1:0] peek_reg;
   logic [31:0] status_reg, status_next;
   logic null_reg, settle_reg, save_open_reg;
   logic cc_true;

   // Instruction field decode
   wire take = link.req_valid & ready_reg;
   wire [2:0] cpid = op_reg[fp_pkg::CPID_LSB +: 3];
   wire [2:0] typ = op_reg[fp_pkg::TYPE_LSB +: 3];
   wire rm = ext_reg[fp_pkg::RM_BIT];
   wire [2:0] spec = ext_reg[fp_pkg::SPEC_LSB +: 3];
   wire [2:0] dsti = ext_reg[fp_pkg::DST_LSB +: 3];
   wire [5:0] pred = ext_reg[fp_pkg::PRED_W-1:0];
   wire is_scale = typ == fp_pkg::TYPE_GENERAL &&
      ext_reg[6:0] == fp_pkg::OPMODE_SCALE;
   wire is_scc = typ == fp_pkg::TYPE_SETCC;
   wire is_save = typ == fp_pkg::TYPE_SAVE;
   wire fp_pkg::ea_kind_t kind = is_save ? fp_pkg::EA_FOR_SAVE :
      is_scc ? fp_pkg::EA_FOR_SETCC :
      (is_scale && rm) ? fp_pkg::EA_FOR_SCALE : fp_pkg::EA_FOR_NONE;
   logic ea_ok;

   ea_mode_check u_ea_check (
      .i_kind(kind),
      .i_mode(op_reg[5:3]),
      .i_reg(op_reg[2:0]),
      .i_fmt(spec),
      .o_legal(ea_ok)
   );

   // Verdict on the latched instruction; upper extension bits must be zero for set-on-condition
   wire in_exec = state_reg == ST_EXEC;
   wire not_mine = cpid != CPID;
   wire unsup = !(is_scale || is_scc || is_save);
   wire bad = !ea_ok || (is_scc && ext_reg[15:6] != 10'h000);
   wire run = in_exec && !not_mine && !unsup && !bad;
   wire do_scale = run && is_scale;
   wire do_scc = run && is_scc;
   wire do_save = run && is_save;

   // Operand classification; memory source already in extended form
   wire [79:0] dst = fpr_reg[dsti];
   wire [79:0] src = rm ? opnd_reg : fpr_reg[spec];
   wire s_sgn = src[79];
   wire [14:0] s_exp = src[78:64];
   wire [63:0] s_man = src[63:0];
   wire d_sgn = dst[79];
   wire [14:0] d_exp = dst[78:64];
   wire s_top = s_exp == fp_pkg::EXP_MAX;
   wire d_top = d_exp == fp_pkg::EXP_MAX;
   wire s_zero = s_exp == 15'h0000 && s_man == 64'h0;
   wire d_zero = d_exp == 15'h0000 && dst[63:0] == 64'h0;
   wire s_inf = s_top && s_man[62:0] == 63'h0;
   wire s_nan = s_top && !s_inf;
   wire d_inf = d_top && dst[62:0] == 63'h0;
   wire d_nan = d_top && !d_inf;

   // Chop the source to an integer; below one it is zero
   wire s_big = s_exp >= fp_pkg::SCALE_BIG_EXP;
   wire s_frac = s_exp < fp_pkg::EXP_BIAS;
   wire [14:0] s_unb = s_exp - fp_pkg::EXP_BIAS;
   wire [5:0] sh = fp_pkg::MAN_TOP - s_unb[5:0];
   wire [63:0] s_shift = s_man >> sh;
   wire [13:0] s_int = s_frac ? 14'h0000 : s_shift[13:0];
   // Exponent sum; bit 16 flags a negative result
   wire [16:0] d_ext = {2'b00, d_exp};
   wire [16:0] sum = s_sgn ? d_ext - {3'b000, s_int} :
      d_ext + {3'b000, s_int};
   wire sc_ovf = s_big ? !s_sgn :
      (!sum[16] && sum[15:0] >= {1'b0, fp_pkg::EXP_MAX});
   wire sc_unf = s_big ? s_sgn : (sum[16] || sum == 17'h0);
   wire [79:0] scaled = sc_ovf ? {d_sgn, fp_pkg::EXP_MAX, 64'h0} :
      sc_unf ? {d_sgn, 79'h0} : {d_sgn, sum[14:0], dst[63:0]};

   // Special-case selection, NANs first
   wire [79:0] qbit = 80'h1 << fp_pkg::QUIET_BIT;
   wire sc_path = !(s_nan || d_nan || s_inf || d_zero || d_inf || s_zero);
   wire [79:0] res = s_nan ? (src | qbit) : d_nan ? (dst | qbit) :
      s_inf ? fp_pkg::QNAN_VALUE :
      (d_zero || d_inf || s_zero) ? dst : scaled;
   wire f_signaling_nan_flag = (s_nan && !s_man[fp_pkg::QUIET_BIT]) ||
      (d_nan && !dst[fp_pkg::QUIET_BIT]);
   wire f_operand_error_flag = s_inf;
   wire f_overflow_flag = sc_path && sc_ovf;
   wire f_underflow_flag = sc_path && sc_unf;
   wire r_zero = res[78:0] == 79'h0;
   wire r_inf = res[78:64] == fp_pkg::EXP_MAX && res[62:0] == 63'h0;
   wire r_nan = res[78:64] == fp_pkg::EXP_MAX && !r_inf;

   // Floating condition evaluation from the status condition bits
   wire c_n = status_reg[fp_pkg::CC_N];
   wire c_z = status_reg[fp_pkg::CC_Z];
   wire c_u = status_reg[fp_pkg::CC_NAN];
   always_comb begin
      case (pred[3:0])
         4'h0: cc_true = 1'b0;
         4'h1: cc_true = c_z;
         4'h2: cc_true = !(c_u || c_z || c_n);
         4'h3: cc_true = c_z || !(c_u || c_n);
         4'h4: cc_true = c_n && !(c_u || c_z);
         4'h5: cc_true = c_z || (c_n && !c_u);
         4'h6: cc_true = !(c_u || c_z);
         4'h7: cc_true = !c_u;
         4'h8: cc_true = c_u;
         4'h9: cc_true = c_u || c_z;
         4'ha: cc_true = c_u || !(c_n || c_z);
         4'hb: cc_true = c_u || c_z || !c_n;
         4'hc: cc_true = c_u || (c_n && !c_z);
         4'hd: cc_true = c_u || c_z || c_n;
         4'he: cc_true = !c_z;
         default: cc_true = 1'b1;
      endcase
   end
   wire f_unordered_branch_flag = c_u && pred[fp_pkg::PRED_NONAWARE_BIT];

   // Status word update; save leaves it alone
   always_comb begin
      status_next = status_reg;
      if (do_scale) begin
         status_next[31:24] = {4'h0, res[79] & !r_nan, r_zero, r_inf, r_nan};
         status_next[fp_pkg::EXC_UNORDERED_BRANCH_FLAG] = 1'b0;
         status_next[fp_pkg::EXC_SIGNALING_NAN_FLAG] = f_signaling_nan_flag;
         status_next[fp_pkg::EXC_OPERAND_ERROR_FLAG] = f_operand_error_flag;
         status_next[fp_pkg::EXC_OVERFLOW_FLAG] = f_overflow_flag;
         status_next[fp_pkg::EXC_UNDERFLOW_FLAG] = f_underflow_flag;
         status_next[fp_pkg::EXC_DZ] = 1'b0;
         status_next[fp_pkg::EXC_INEXACT_RESULT_FLAG] = 1'b0;
         if (!(rm && spec == fp_pkg::FMT_PACKED)) begin
            status_next[fp_pkg::EXC_INEXACT_DECIMAL_INPUT_FLAG] = 1'b0;
         end
         status_next[fp_pkg::ACC_IOP] = status_reg[fp_pkg::ACC_IOP] |
            f_signaling_nan_flag | f_operand_error_flag;
         status_next[fp_pkg::ACC_OVERFLOW_FLAG] = status_reg[fp_pkg::ACC_OVERFLOW_FLAG] | f_overflow_flag;
         status_next[fp_pkg::ACC_UNDERFLOW_FLAG] = status_reg[fp_pkg::ACC_UNDERFLOW_FLAG] | f_underflow_flag;
         status_next[fp_pkg::ACC_INEX] = status_reg[fp_pkg::ACC_INEX] | f_overflow_flag;
      end else if (do_scc) begin
         // Only the unordered flag and invalid accrual may move
         status_next[fp_pkg::EXC_UNORDERED_BRANCH_FLAG] = status_reg[fp_pkg::EXC_UNORDERED_BRANCH_FLAG] |
            f_unordered_branch_flag;
         status_next[fp_pkg::ACC_IOP] = status_reg[fp_pkg::ACC_IOP] |
            status_next[fp_pkg::EXC_UNORDERED_BRANCH_FLAG];
      end else if (i_status_load) begin
         status_next = i_status_value;
      end
   end

   // Save answer: open save, then settling work, then frame
   wire [15:0] frame = save_open_reg ? fp_pkg::FRAME_ILLEGAL :
      settle_reg ? fp_pkg::FRAME_NOT_READY :
      null_reg ? fp_pkg::FRAME_NULL :
      {VERSION, fp_pkg::FRAME_IDLE_LOW};
   wire frame_saved = !save_open_reg && !settle_reg;
   assign code_next = not_mine ? fp_pkg::RESP_NOT_MINE :
      unsup ? fp_pkg::RESP_UNSUPPORTED :
      bad ? fp_pkg::RESP_ILLEGAL : fp_pkg::RESP_OK;
   assign data_next = do_save ? frame :
      do_scc ? {8'h00, {8{cc_true}}} : 16'h0000;

   // Sequencer: take, execute, answer
   always_comb begin
      case (state_reg)
         ST_IDLE: state_next = take ? ST_EXEC : ST_IDLE;
         ST_EXEC: state_next = ST_RESP;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= ST_IDLE;
         ready_reg <= 1'b1;
         resp_valid_reg <= 1'b0;
         code_reg <= fp_pkg::RESP_OK;
         data_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         ready_reg <= state_next == ST_IDLE;
         resp_valid_reg <= in_exec;
         if (in_exec) begin
            code_reg <= code_next;
            data_reg <= data_next;
         end
      end
   end

   // Request capture
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         op_reg <= 16'h0000;
         ext_reg <= 16'h0000;
         opnd_reg <= '0;
      end else if (take) begin
         op_reg <= link.opword;
         ext_reg <= link.extword;
         opnd_reg <= link.operand;
      end
   end

   // Save bookkeeping; settle covers the cycle a scale wraps up in
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         null_reg <= 1'b1;
         settle_reg <= 1'b0;
         save_open_reg <= 1'b0;
      end else begin
         if (do_scale || do_scc || i_load_valid || i_status_load) begin
            null_reg <= 1'b0;
         end
         if (in_exec) begin
            settle_reg <= do_scale;
            save_open_reg <= do_save ? (save_open_reg | frame_saved) :
               1'b0;
         end else if (state_reg == ST_IDLE && !take) begin
            settle_reg <= 1'b0;
         end
      end
   end

   // Data registers start as quiet NANs; execution wins over preload
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int i = 0; i < 8; i++) begin
            fpr_reg[i] <= fp_pkg::QNAN_VALUE;
         end
         status_reg <= fp_pkg::STATUS_RESET;
         peek_reg <= '0;
      end else begin
         if (do_scale) begin
            fpr_reg[dsti] <= res;
         end else if (i_load_valid) begin
            fpr_reg[i_load_idx] <= i_load_value;
         end
         status_reg <= status_next;
         peek_reg <= fpr_reg[i_peek_idx];
      end
   end

   assign link.req_ready = ready_reg;
   assign link.resp_valid = resp_valid_reg;
   assign link.resp_code = code_reg;
   assign link.resp_data = data_reg;
   assign o_peek_value = peek_reg;
   assign o_status_word = status_reg;
endmodule : fp_coproc_device

// File: src/fp_host_end.sv
// Main processor end: forms opwords, screens addressing, runs the link
`timescale 1ns/1ps
module fp_host_end #(
   parameter logic [2:0] CPID = fp_pkg::CPID_DEFAULT
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Commands from the user
   input wire logic i_cmd_valid,
   input wire logic [15:0] i_cmd_opword,
   input wire logic [15:0] i_cmd_extword,
   input wire logic [fp_pkg::XW-1:0] i_cmd_operand,
   output logic o_cmd_ready,
   output logic o_done,
   output fp_pkg::resp_code_t o_done_code,
   output logic [15:0] o_done_data,
   // Link to the coprocessor
   fp_link_if.host link
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SEND = 2'b01,
      H_WAIT = 2'b10
   } host_state_t;

   host_state_t state_reg;
   logic req_valid_reg, done_reg, cmd_ready_reg;
   logic [15:0] op_reg, ext_reg;
   logic [fp_pkg::XW-1:0] opnd_reg;
   fp_pkg::resp_code_t code_reg;
   logic [15:0] data_reg;
   logic ea_ok;

   // Screen the command before it reaches the link
   wire [2:0] typ = i_cmd_opword[fp_pkg::TYPE_LSB +: 3];
   wire rm = i_cmd_extword[fp_pkg::RM_BIT];
   wire is_general = typ == fp_pkg::TYPE_GENERAL;
   wire is_scale = is_general && i_cmd_extword[6:0] == fp_pkg::OPMODE_SCALE;
   wire fp_pkg::ea_kind_t kind =
      (typ == fp_pkg::TYPE_SAVE) ? fp_pkg::EA_FOR_SAVE :
      (typ == fp_pkg::TYPE_SETCC) ? fp_pkg::EA_FOR_SETCC :
      (is_scale && rm) ? fp_pkg::EA_FOR_SCALE : fp_pkg::EA_FOR_NONE;

   ea_mode_check u_ea_check (
      .i_kind(kind),
      .i_mode(i_cmd_opword[5:3]),
      .i_reg(i_cmd_opword[2:0]),
      .i_fmt(i_cmd_extword[fp_pkg::SPEC_LSB +: 3]),
      .o_legal(ea_ok)
   );

   // Id field forced; unused address field zeroed for register sources
   wire [5:0] ea_out = (is_general && !rm) ? 6'h00 :
      i_cmd_opword[5:0];
   wire [15:0] op_out = {i_cmd_opword[15:12], CPID,
      i_cmd_opword[8:6], ea_out};
   wire take = i_cmd_valid && state_reg == H_IDLE;
   wire sent = req_valid_reg && link.req_ready;

   // Illegal addressing is refused locally, never sent
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= H_IDLE;
         req_valid_reg <= 1'b0;
         done_reg <= 1'b0;
         cmd_ready_reg <= 1'b1;
         code_reg <= fp_pkg::RESP_OK;
         data_reg <= 16'h0000;
         op_reg <= 16'h0000;
         ext_reg <= 16'h0000;
         opnd_reg <= '0;
      end else begin
         done_reg <= 1'b0;
         case (state_reg)
            H_IDLE: begin
               if (take && !ea_ok) begin
                  done_reg <= 1'b1;
                  code_reg <= fp_pkg::RESP_ILLEGAL;
                  data_reg <= 16'h0000;
               end else if (take) begin
                  state_reg <= H_SEND;
                  cmd_ready_reg <= 1'b0;
                  req_valid_reg <= 1'b1;
                  op_reg <= op_out;
                  ext_reg <= i_cmd_extword;
                  opnd_reg <= i_cmd_operand;
               end
            end
            H_SEND: begin
               if (sent) begin
                  state_reg <= H_WAIT;
                  req_valid_reg <= 1'b0;
               end
            end
            default: begin
               if (link.resp_valid) begin
                  state_reg <= H_IDLE;
                  done_reg <= 1'b1;
                  cmd_ready_reg <= 1'b1;
                  code_reg <= link.resp_code;
                  data_reg <= link.resp_data;
               end
            end
         endcase
      end
   end

   // Ready kept in its own flop so the user sees no decode glitch
   assign o_cmd_ready = cmd_ready_reg;
   assign o_done = done_reg;
   assign o_done_code = code_reg;
   assign o_done_data = data_reg;
   assign link.req_valid = req_valid_reg;
   assign link.opword = op_reg;
   assign link.extword = ext_reg;
   assign link.operand = opnd_reg;
endmodule : fp_host_end

// File: src/fp_link_if.sv
// Coprocessor link between the main processor end and the device end
`timescale 1ns/1ps
interface fp_link_if;
   logic req_valid;
   logic req_ready;
   logic [15:0] opword;
   logic [15:0] extword;
   logic [fp_pkg::XW-1:0] operand;
   logic resp_valid;
   fp_pkg::resp_code_t resp_code;
   logic [15:0] resp_data;
   modport dev(input req_valid, input opword, input extword,
      input operand, output req_ready, output resp_valid,
      output resp_code, output resp_data);
   modport host(output req_valid, output opword, output extword,
      output operand, input req_ready, input resp_valid,
      input resp_code, input resp_data);
endinterface : fp_link_if

// File: src/fp_pkg.sv
// Shared constants and types for the float coprocessor link and both ends
package fp_pkg;
   localparam int XW = 80;
   // Opword and extension word field positions
   localparam int CPID_LSB = 9;
   localparam int TYPE_LSB = 6;
   localparam int RM_BIT = 14;
   localparam int SPEC_LSB = 10;
   localparam int DST_LSB = 7;
   localparam int PRED_NONAWARE_BIT = 4;
   localparam int PRED_W = 6;
   localparam logic [2:0] CPID_DEFAULT = 3'h1;
   localparam logic [2:0] TYPE_GENERAL = 3'h0;
   localparam logic [2:0] TYPE_SETCC = 3'h1;
   localparam logic [2:0] TYPE_SAVE = 3'h4;
   localparam logic [6:0] OPMODE_SCALE = 7'h26;
   // Source formats when the source-mode bit is set
   localparam logic [2:0] FMT_LONG = 3'h0;
   localparam logic [2:0] FMT_SINGLE = 3'h1;
   localparam logic [2:0] FMT_EXT = 3'h2;
   localparam logic [2:0] FMT_PACKED = 3'h3;
   localparam logic [2:0] FMT_WORD = 3'h4;
   localparam logic [2:0] FMT_DOUBLE = 3'h5;
   localparam logic [2:0] FMT_BYTE = 3'h6;
   // Effective address modes and mode-7 register codes
   localparam logic [2:0] EA_DREG = 3'h0;
   localparam logic [2:0] EA_AREG = 3'h1;
   localparam logic [2:0] EA_IND = 3'h2;
   localparam logic [2:0] EA_POSTINC = 3'h3;
   localparam logic [2:0] EA_PREDEC = 3'h4;
   localparam logic [2:0] EA_DISP = 3'h5;
   localparam logic [2:0] EA_INDEX = 3'h6;
   localparam logic [2:0] EA_EXT = 3'h7;
   localparam logic [2:0] EXT_ABS_W = 3'h0;
   localparam logic [2:0] EXT_ABS_L = 3'h1;
   localparam logic [2:0] EXT_IMM = 3'h4;
   // Save format words
   localparam logic [15:0] FRAME_NULL = 16'h0018;
   localparam logic [15:0] FRAME_NOT_READY = 16'h0118;
   localparam logic [15:0] FRAME_ILLEGAL = 16'h0218;
   localparam logic [7:0] FRAME_IDLE_LOW = 8'h18;
   localparam logic [7:0] VERSION_DEFAULT = 8'h21; // Arbitrary value
   // Extended format numbers
   localparam logic [14:0] EXP_BIAS = 15'h3fff;
   localparam logic [14:0] EXP_MAX = 15'h7fff;
   localparam logic [14:0] SCALE_BIG_EXP = 15'h400d; // Bias plus 14
   localparam logic [5:0] MAN_TOP = 6'h3f;
   localparam int QUIET_BIT = 62;
   localparam logic [79:0] QNAN_VALUE = 80'h7fff_ffff_ffff_ffff_ffff;
   // Status word bit positions
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam int CC_N = 27;
   localparam int CC_Z = 26;
   localparam int CC_I = 25;
   localparam int CC_NAN = 24;
   localparam int EXC_UNORDERED_BRANCH_FLAG = 15;
   localparam int EXC_SIGNALING_NAN_FLAG = 14;
   localparam int EXC_OPERAND_ERROR_FLAG = 13;
   localparam int EXC_OVERFLOW_FLAG = 12;
   localparam int EXC_UNDERFLOW_FLAG = 11;
   localparam int EXC_DZ = 10;
   localparam int EXC_INEXACT_RESULT_FLAG = 9;
   localparam int EXC_INEXACT_DECIMAL_INPUT_FLAG = 8;
   localparam int ACC_IOP = 7;
   localparam int ACC_OVERFLOW_FLAG = 6;
   localparam int ACC_UNDERFLOW_FLAG = 5;
   localparam int ACC_INEX = 3;
   typedef enum logic [1:0] {
      RESP_OK = 2'b00,
      RESP_ILLEGAL = 2'b01,
      RESP_NOT_MINE = 2'b10,
      RESP_UNSUPPORTED = 2'b11
   } resp_code_t;
   typedef enum logic [1:0] {
      EA_FOR_SAVE = 2'b00,
      EA_FOR_SCALE = 2'b01,
      EA_FOR_SETCC = 2'b10,
      EA_FOR_NONE = 2'b11
   } ea_kind_t;
endpackage : fp_pkg

// File: verification/fp_link_asserts.sv
// Link timing and host screening checks
`timescale 1ns/1ps
module fp_link_asserts (
   // Clock and reset
   input logic i_clk,
   input logic i_reset_n,
   // Link signals
   input logic i_req_valid,
   input logic i_req_ready,
   input logic [15:0] i_opword,
   input logic [15:0] i_extword,
   input logic i_resp_valid,
   input fp_pkg::resp_code_t i_resp_code,
   input logic [15:0] i_resp_data
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // Decoded request kinds; source screening only binds the scale op
   wire tk = i_req_valid && i_req_ready;
   wire gen = i_req_valid && i_opword[8:6] == fp_pkg::TYPE_GENERAL;
   wire sc = gen && i_extword[14] &&
      i_extword[6:0] == fp_pkg::OPMODE_SCALE;
   wire ok = i_resp_valid && i_resp_code == fp_pkg::RESP_OK;
   answer_time_a: assert property (tk |=> !i_req_ready ##1
      (!i_req_ready && i_resp_valid) ##1 i_req_ready)
      else $error("answer timing");
   cpid_field_a: assert property (
      i_req_valid |-> i_opword[11:9] == fp_pkg::CPID_DEFAULT)
      else $error("id field");
   save_mode_a: assert property (
      i_req_valid && i_opword[8:6] == fp_pkg::TYPE_SAVE |->
      i_opword[5:3] inside {3'h2, 3'h4, 3'h5, 3'h6, 3'h7} &&
      (i_opword[5:3] != 3'h7 || i_opword[2:1] == 2'h0))
      else $error("save mode");
   ea_zero_a: assert property (gen && !i_extword[14] |->
      i_opword[5:0] == 6'h00) else $error("address field not zero");
   no_areg_a: assert property (sc |-> i_opword[5:3] != 3'h1)
      else $error("address register source");
   dreg_fmt_a: assert property (
      sc && i_opword[5:3] == 3'h0 |->
      i_extword[12:10] inside {3'h0, 3'h1, 3'h4, 3'h6})
      else $error("data register format");
   save_word_a: assert property (
      ok && $past(i_opword[8:6], 2) == fp_pkg::TYPE_SAVE |->
      i_resp_data[7:0] == 8'h18) else $error("save word");
   setcc_byte_a: assert property (
      ok && $past(i_opword[8:6], 2) == fp_pkg::TYPE_SETCC |->
      i_resp_data inside {16'h00ff, 16'h0000}) else $error("set byte");
endmodule : fp_link_asserts

// File: verification/tb_top.sv
// Bench joining host and device ends over the link
`timescale 1ns/1ps
module tb_top;
   localparam logic [79:0] ONE = {1'b0, 15'h3fff, 64'h8000_0000_0000_0000};
   logic i_clk = 0;
   logic i_reset_n = 0;
   logic cv = 0, lv = 0, sl = 0, crdy, dn;
   logic [15:0] op = 0, ex = 0, ddata;
   logic [79:0] opd = 0, lval = 0, peek;
   logic [2:0] li = 0, pidx = 0;
   logic [31:0] sval = 0, stat;
   fp_pkg::resp_code_t dcode;
   int failures = 0;
   int comparisons = 0;
   fp_link_if lnk ();
   always #5 i_clk = ~i_clk;
   fp_host_end u_fp_host_end (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_cmd_valid(cv), .i_cmd_opword(op), .i_cmd_extword(ex),
      .i_cmd_operand(opd), .o_cmd_ready(crdy), .o_done(dn),
      .o_done_code(dcode), .o_done_data(ddata), .link(lnk));
   fp_coproc_device u_fp_coproc_device (.i_clk(i_clk),
      .i_reset_n(i_reset_n), .link(lnk), .i_load_valid(lv),
      .i_load_idx(li), .i_load_value(lval), .i_status_load(sl),
      .i_status_value(sval), .i_peek_idx(pidx), .o_peek_value(peek),
      .o_status_word(stat));
   fp_link_asserts u_fp_link_asserts (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_req_valid(lnk.req_valid), .i_req_ready(lnk.req_ready),
      .i_opword(lnk.opword), .i_extword(lnk.extword),
      .i_resp_valid(lnk.resp_valid), .i_resp_code(lnk.resp_code),
      .i_resp_data(lnk.resp_data));
   // Wide enough for a register value joined with a status byte
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One command, waiting a bounded time since a lost done must not hang
   task automatic cmd(input logic [15:0] o, input logic [15:0] e);
      int n;
      n = 0;
      @(posedge i_clk) #1;
      op = o;
      ex = e;
      cv = 1;
      @(posedge i_clk) #1;
      cv = 0;
      while (dn !== 1'b1 && n < 20) begin
         @(posedge i_clk) #1;
         n++;
      end
      chk(dn, 1'b1);
      chk(crdy, 1'b1);
   endtask : cmd
   task automatic load(input logic [2:0] i, input logic [79:0] v);
      @(posedge i_clk) #1;
      li = i;
      lval = v;
      lv = 1;
      @(posedge i_clk) #1;
      lv = 0;
   endtask : load
   task automatic stload(input logic [31:0] v);
      @(posedge i_clk) #1;
      sval = v;
      sl = 1;
      @(posedge i_clk) #1;
      sl = 0;
   endtask : stload
   task automatic peekr(input logic [2:0] i);
      pidx = i;
      @(posedge i_clk) #1;
   endtask : peekr
   task automatic t_null;
      cmd(16'hf310, 16'h0);
      chk(ddata, fp_pkg::FRAME_NULL);
      cmd(16'hf318, 16'h0);
      chk(dcode, fp_pkg::RESP_ILLEGAL);
   endtask : t_null
   // Source 2.5 chops to 2; then refused and legal register sources
   task automatic t_scale;
      stload(32'h0000_ff00);
      load(3'h1, ONE);
      load(3'h2, {1'b0, 15'h4000, 64'ha000_0000_0000_0000});
      cmd(16'hf200, 16'h08a6);
      peekr(3'h1);
      chk(peek, {1'b0, 15'h4001, 64'h8000_0000_0000_0000});
      chk(stat[15:8], 8'h00);
      chk(dcode, fp_pkg::RESP_OK);
      cmd(16'hf200, 16'h48a6);
      chk(dcode, fp_pkg::RESP_ILLEGAL);
      cmd(16'hf208, 16'h40a6);
      chk(dcode, fp_pkg::RESP_ILLEGAL);
      opd = ONE;
      cmd(16'hf200, 16'h40a6);
      peekr(3'h1);
      chk(peek[78:64], 15'h4002);
      // General op with another opmode is not ours to run
      cmd(16'hf200, 16'h0000);
      chk(dcode, fp_pkg::RESP_UNSUPPORTED);
   endtask : t_scale
   task automatic t_special;
      load(3'h3, {1'b0, 15'h7fff, 64'h0});
      cmd(16'hf200, 16'h0ca6);
      peekr(3'h1);
      chk({peek, stat[15:8]}, {fp_pkg::QNAN_VALUE, 8'h20});
      load(3'h1, {1'b1, 15'h7fff, 64'h0});
      load(3'h4, ONE);
      cmd(16'hf200, 16'h10a6);
      peekr(3'h1);
      chk(peek, {1'b1, 15'h7fff, 64'h0});
      load(3'h1, ONE);
      load(3'h4, {1'b0, 15'h400d, 64'h8000_0000_0000_0000});
      cmd(16'hf200, 16'h10a6);
      peekr(3'h1);
      chk({peek[78:64], stat[12]}, {15'h7fff, 1'b1});
      load(3'h1, ONE);
      load(3'h4, 80'h0);
      cmd(16'hf200, 16'h10a6);
      peekr(3'h1);
      chk({peek, stat[15:8]}, {ONE, 8'h00});
   endtask : t_special
   // NAN code set: aware true, non-aware false, nonzero upper bits
   task automatic t_setcc;
      stload(32'h015a_0000);
      cmd(16'hf240, 16'h000f);
      chk({ddata, stat}, {16'h00ff, 32'h015a_0000});
      cmd(16'hf240, 16'h0010);
      chk({ddata, stat}, {16'h0000, 32'h015a_8080});
      cmd(16'hf240, 16'h0440);
      chk(dcode, fp_pkg::RESP_ILLEGAL);
   endtask : t_setcc
   task automatic t_save2;
      cmd(16'hf328, 16'h0);
      chk(ddata, {fp_pkg::VERSION_DEFAULT, 8'h18});
      cmd(16'hf338, 16'h0);
      chk({ddata, stat}, {fp_pkg::FRAME_ILLEGAL, 32'h015a_8080});
   endtask : t_save2
   task automatic final_report;
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   initial begin
      repeat (10) @(posedge i_clk);
      #1 i_reset_n = 1;
      t_null;
      t_scale;
      t_special;
      t_setcc;
      t_save2;
      final_report;
   end
   // Watchdog well past the hundred or so cycles the tests need
   initial begin
      #100000;
      failures++;
      final_report;
   end
endmodule : tb_top
